/* src/uart_host_reset_irq_chain.sv */
// Host-side control of a dual serial controller: reset values,
// chip-selected data bus, alternate pin clocks, interrupt chain.
// Assumes asynchronous host pins; tx data and events share clock.
//
// Notes on behaviour
// - Reset clears channel status, irq status, mask, output port, config.
// - Reset loads the interrupt vector with 0F hex.
// - Reset halts the timer until software restarts it.
// - Reset drives all eight general outputs high.
// - Reset idles both channels with transmit lines marking high.
// - Data bus is released while chip select is high.
// - Transfers happen only while the host holds chip select low.
// - Input 2 may clock the timer.
// - Input 6 may clock receiver B, only when chain mode is off.
// - Input 5 may clock transmitter B.
// - Input 4 may clock receiver A, only when chain mode is off.
// - Acknowledge read cycle returns the interrupt vector.
// - Chain enable out follows a low chain enable in.
// - Chain enable out stays low from request until end of service.
// - Enable in high lets unmasked events request.
// - Enable in low blocks every request.
`timescale 1ns/1ns
`default_nettype none
module uart_host_reset_irq_chain #(
	parameter bit CHAIN_MODE = 1'b1,
	parameter int TICK_CYCLES = uart_ctl_pkg::TICK_CYCLES
) (
	input wire logic clock,
	input wire logic reset,
	input wire uart_ctl_pkg::host_bus_t host_bus,
	output logic [7:0] host_data_out,
	output logic host_data_oe,
	input wire logic [6:0] gp_inputs,
	input wire logic irq_ack_n,
	input wire logic chain_enable_in,
	input wire logic [7:0] irq_events,
	input wire logic [7:0] chan_status_in,
	input wire logic tx_data_a,
	input wire logic tx_data_b,
	output logic [7:0] gp_outputs,
	output logic tx_line_a,
	output logic tx_line_b,
	output logic irq_request_n,
	output logic chain_enable_out,
	output logic timer_ext_clock,
	output logic rx_ext_clock_a,
	output logic tx_ext_clock_b,
	output logic rx_ext_clock_b,
	output logic timer_running
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	localparam uart_ctl_pkg::host_bus_t BUS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
		addr: 4'h0, data: 8'h00};
	localparam logic [8:0] PIN_IDLE = 9'h180;

	uart_ctl_pkg::host_bus_t hb;
	uart_ctl_pkg::host_bus_t hb_reg;
	logic [8:0] pins;
	logic [6:0] gp_in;
	logic ack_low;
	logic chain_in;

	sync2 #(.WIDTH(uart_ctl_pkg::HOST_BUS_W), .INIT(BUS_IDLE)) bus_sync (
		.clock(clock),
		.reset(reset),
		.async_in(host_bus),
		.sync_out(hb)
	);

	sync2 #(.WIDTH(9), .INIT(PIN_IDLE)) pin_sync (
		.clock(clock),
		.reset(reset),
		.async_in({irq_ack_n, chain_enable_in, gp_inputs}),
		.sync_out(pins)
	);

	assign gp_in = pins[6:0];
	assign chain_in = pins[7];
	assign ack_low = CHAIN_MODE && !pins[8];

	// Strobe edge helper, shared by read and write
	function automatic logic fell(input logic now, input logic was);
		fell = !now && was;
	endfunction

	// ----------------------------------------
	// Host bus strobes
	// ----------------------------------------
	logic wr_strobe;
	logic rd_start;
	logic rd_end;
	logic wr_cmd;
	logic [7:0] cmd;

	always_comb begin
		wr_strobe = !hb.cs_n && fell(hb.wr_n, hb_reg.wr_n);
		rd_start = !hb.cs_n && fell(hb.rd_n, hb_reg.rd_n);
		rd_end = !hb_reg.cs_n && fell(!hb.rd_n, !hb_reg.rd_n);
		wr_cmd = wr_strobe && hb.addr == uart_ctl_pkg::ADDR_COMMAND;
		cmd = wr_cmd ? hb.data : 8'h00;
	end

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	logic [7:0] chan_status_reg, chan_status_next;
	logic [7:0] irq_status_reg, irq_status_next;
	logic [7:0] irq_mask_reg, irq_mask_next;
	logic [7:0] output_port_reg, output_port_next;
	logic [7:0] output_port_config_reg, output_port_config_next;
	logic [7:0] irq_vector_reg, irq_vector_next;
	logic [3:0] clk_sel_reg, clk_sel_next;
	logic [15:0] preload_reg, preload_next;
	logic timer_done;

	always_comb begin
		chan_status_next = chan_status_in;
		irq_status_next = irq_status_reg;
		irq_mask_next = irq_mask_reg;
		output_port_next = output_port_reg;
		output_port_config_next = output_port_config_reg;
		irq_vector_next = irq_vector_reg;
		clk_sel_next = clk_sel_reg;
		preload_next = preload_reg;
		if (wr_strobe) begin
			case (hb.addr)
				uart_ctl_pkg::ADDR_IRQ_STATUS: begin
					irq_status_next = irq_status_reg & ~hb.data;
				end
				uart_ctl_pkg::ADDR_IRQ_MASK: begin
					irq_mask_next = hb.data;
				end
				uart_ctl_pkg::ADDR_OUT_PORT: begin
					output_port_next = hb.data;
				end
				uart_ctl_pkg::ADDR_OUT_CFG: begin
					output_port_config_next = hb.data;
				end
				uart_ctl_pkg::ADDR_VECTOR: begin
					irq_vector_next = hb.data;
				end
				uart_ctl_pkg::ADDR_CLK_SEL: begin
					clk_sel_next = hb.data[3:0];
				end
				uart_ctl_pkg::ADDR_PRELOAD_HI: begin
					preload_next[15:8] = hb.data;
				end
				uart_ctl_pkg::ADDR_PRELOAD_LO: begin
					preload_next[7:0] = hb.data;
				end
				default: begin
				end
			endcase
		end
		// Events set after the clear so a same-cycle event survives
		irq_status_next = irq_status_next | irq_events;
		irq_status_next[uart_ctl_pkg::IRQ_TIMER_BIT] =
			irq_status_next[uart_ctl_pkg::IRQ_TIMER_BIT] | timer_done;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			chan_status_reg <= uart_ctl_pkg::CLEAR_RESET;
			irq_status_reg <= uart_ctl_pkg::CLEAR_RESET;
			irq_mask_reg <= uart_ctl_pkg::CLEAR_RESET;
			output_port_reg <= uart_ctl_pkg::CLEAR_RESET;
			output_port_config_reg <= uart_ctl_pkg::CLEAR_RESET;
			irq_vector_reg <= uart_ctl_pkg::VECTOR_RESET;
			clk_sel_reg <= 4'h0;
			preload_reg <= uart_ctl_pkg::PRELOAD_RESET;
		end else begin
			chan_status_reg <= chan_status_next;
			irq_status_reg <= irq_status_next;
			irq_mask_reg <= irq_mask_next;
			output_port_reg <= output_port_next;
			output_port_config_reg <= output_port_config_next;
			irq_vector_reg <= irq_vector_next;
			clk_sel_reg <= clk_sel_next;
			preload_reg <= preload_next;
		end
	end

	// ----------------------------------------
	// Alternate clock functions of inputs
	// ----------------------------------------
	logic [6:0] gp_prev_reg;
	logic [3:0] clk_pulse_reg, clk_pulse_next;
	logic [6:0] rise;
	logic chain_pins;

	// Pins 4 and 6 carry chain signals in chain mode, so no clock there
	always_comb begin
		rise = gp_in & ~gp_prev_reg;
		chain_pins = CHAIN_MODE;
		clk_pulse_next[uart_ctl_pkg::SEL_TIMER_EXT] = clk_sel_reg[uart_ctl_pkg::SEL_TIMER_EXT] && rise[2];
		// input 4 as receiver A clock
		clk_pulse_next[uart_ctl_pkg::SEL_RX_CLK_A] = clk_sel_reg[uart_ctl_pkg::SEL_RX_CLK_A] && rise[4]
			&& !chain_pins;
		// input 5 as transmitter B clock
		clk_pulse_next[uart_ctl_pkg::SEL_TX_CLK_B] = clk_sel_reg[uart_ctl_pkg::SEL_TX_CLK_B] && rise[5];
		// input 6 as receiver B clock
		clk_pulse_next[uart_ctl_pkg::SEL_RX_CLK_B] = clk_sel_reg[uart_ctl_pkg::SEL_RX_CLK_B] && rise[6]
			&& !chain_pins;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			gp_prev_reg <= 7'h00;
			clk_pulse_reg <= 4'h0;
		end else begin
			gp_prev_reg <= gp_in;
			clk_pulse_reg <= clk_pulse_next;
		end
	end

	// ----------------------------------------
	// Counter/timer
	// ----------------------------------------
	logic run_reg, run_next;
	logic [15:0] count_reg, count_next;
	logic [15:0] tick_reg, tick_next;
	logic done_reg, done_next;
	logic timer_out_reg, timer_out_next;
	logic tick;

	// External clock, when chosen, replaces the internal prescaler
	always_comb begin
		tick_next = tick_reg + 16'h0001;
		tick = 1'b0;
		if (tick_reg == 16'(TICK_CYCLES - 1)) begin
			tick_next = 16'h0000;
			tick = !clk_sel_reg[uart_ctl_pkg::SEL_TIMER_EXT];
		end
		if (clk_pulse_reg[uart_ctl_pkg::SEL_TIMER_EXT]) begin
			tick = 1'b1;
		end
		run_next = run_reg;
		count_next = count_reg;
		done_next = 1'b0;
		timer_out_next = timer_out_reg;
		if (run_reg && tick) begin
			count_next = count_reg - 16'h0001;
			if (count_reg == 16'h0000) begin
				count_next = preload_reg;
				done_next = 1'b1;
				timer_out_next = !timer_out_reg;
			end
		end
		if (cmd[uart_ctl_pkg::CMD_TIMER_START]) begin
			run_next = 1'b1;
			count_next = preload_reg;
		end
		if (cmd[uart_ctl_pkg::CMD_TIMER_STOP]) begin
			run_next = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			run_reg <= 1'b0;
			count_reg <= 16'h0000;
			tick_reg <= 16'h0000;
			done_reg <= 1'b0;
			timer_out_reg <= 1'b0;
		end else begin
			run_reg <= run_next;
			count_reg <= count_next;
			tick_reg <= tick_next;
			done_reg <= done_next;
			timer_out_reg <= timer_out_next;
		end
	end

	assign timer_done = done_reg;

	// ----------------------------------------
	// Channels, outputs and data bus
	// ----------------------------------------
	logic chan_a_reg, chan_a_next;
	logic chan_b_reg, chan_b_next;
	logic tx_a_reg, tx_a_next;
	logic tx_b_reg, tx_b_next;
	logic [7:0] gp_out_reg, gp_out_next;
	logic ack_armed_reg, ack_armed_next;
	logic [7:0] dout_reg, dout_next;
	logic oe_reg, oe_next;
	logic [7:0] read_mux;

	always_comb begin
		chan_a_next = (chan_a_reg || cmd[uart_ctl_pkg::CMD_CHAN_A_ON]) && !cmd[uart_ctl_pkg::CMD_CHAN_A_OFF];
		chan_b_next = (chan_b_reg || cmd[uart_ctl_pkg::CMD_CHAN_B_ON]) && !cmd[uart_ctl_pkg::CMD_CHAN_B_OFF];
		// Idle channel marks high
		tx_a_next = !chan_a_reg || tx_data_a;
		tx_b_next = !chan_b_reg || tx_data_b;
		// Pins show the complement, so a cleared port reads high
		gp_out_next = ~output_port_reg;
		if (output_port_config_reg[uart_ctl_pkg::CFG_TIMER_OUT]) begin
			gp_out_next[uart_ctl_pkg::TIMER_OUT_PIN] = timer_out_reg;
		end
		// Acknowledge arms the next read; set beats the clear
		ack_armed_next = (ack_armed_reg && !rd_end) || ack_low;
		case (hb.addr)
			uart_ctl_pkg::ADDR_CHAN_STATUS: read_mux = chan_status_reg;
			uart_ctl_pkg::ADDR_IRQ_STATUS: read_mux = irq_status_reg;
			uart_ctl_pkg::ADDR_IRQ_MASK: read_mux = irq_mask_reg;
			uart_ctl_pkg::ADDR_OUT_PORT: read_mux = output_port_reg;
			uart_ctl_pkg::ADDR_OUT_CFG: read_mux = output_port_config_reg;
			uart_ctl_pkg::ADDR_VECTOR: read_mux = irq_vector_reg;
			uart_ctl_pkg::ADDR_PRELOAD_HI: read_mux = preload_reg[15:8];
			uart_ctl_pkg::ADDR_PRELOAD_LO: read_mux = preload_reg[7:0];
			uart_ctl_pkg::ADDR_TIMER_HI: read_mux = count_reg[15:8];
			uart_ctl_pkg::ADDR_TIMER_LO: read_mux = count_reg[7:0];
			uart_ctl_pkg::ADDR_CLK_SEL: read_mux = {4'h0, clk_sel_reg};
			uart_ctl_pkg::ADDR_GP_IN: read_mux = {1'b0, gp_in};
			default: read_mux = 8'h00;
		endcase
		dout_next = ack_armed_reg ? irq_vector_reg : read_mux;
		oe_next = !hb.cs_n && !hb.rd_n;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			chan_a_reg <= 1'b0;
			chan_b_reg <= 1'b0;
			tx_a_reg <= 1'b1;
			tx_b_reg <= 1'b1;
			gp_out_reg <= 8'hFF;
			ack_armed_reg <= 1'b0;
			dout_reg <= 8'h00;
			oe_reg <= 1'b0;
			hb_reg <= BUS_IDLE;
		end else begin
			chan_a_reg <= chan_a_next;
			chan_b_reg <= chan_b_next;
			tx_a_reg <= tx_a_next;
			tx_b_reg <= tx_b_next;
			gp_out_reg <= gp_out_next;
			ack_armed_reg <= ack_armed_next;
			dout_reg <= dout_next;
			oe_reg <= oe_next;
			hb_reg <= hb;
		end
	end

	// ----------------------------------------
	// Interrupt chain
	// ----------------------------------------
	irq_chain #(.CHAIN_MODE(CHAIN_MODE)) chain (
		.clock(clock),
		.reset(reset),
		.pending(|(irq_status_reg & irq_mask_reg)),
		.chain_in(chain_in),
		.end_service(cmd[uart_ctl_pkg::CMD_END_SERVICE]),
		.irq_request_n(irq_request_n),
		.chain_enable_out(chain_enable_out)
	);

	assign host_data_out = dout_reg;
	assign host_data_oe = oe_reg;
	assign gp_outputs = gp_out_reg;
	assign tx_line_a = tx_a_reg;
	assign tx_line_b = tx_b_reg;
	assign timer_ext_clock = clk_pulse_reg[uart_ctl_pkg::SEL_TIMER_EXT];
	assign rx_ext_clock_a = clk_pulse_reg[uart_ctl_pkg::SEL_RX_CLK_A];
	assign tx_ext_clock_b = clk_pulse_reg[uart_ctl_pkg::SEL_TX_CLK_B];
	assign rx_ext_clock_b = clk_pulse_reg[uart_ctl_pkg::SEL_RX_CLK_B];
	assign timer_running = run_reg;
endmodule // uart_host_reset_irq_chain
`default_nettype wire

/* src/uart_ctl_pkg.sv */
// Shared constants and carriers for the serial controller host logic.
// Assumes one 25 MHz clock and a synchronous active-high reset.
package uart_ctl_pkg;

	// ----------------------------------------
	// Host bus carrier
	// ----------------------------------------
	typedef struct packed {
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic [3:0] addr;
		logic [7:0] data;
	} host_bus_t;

	localparam int HOST_BUS_W = 15;
	localparam int GP_IN_W = 7;

	// ----------------------------------------
	// Register addresses
	// ----------------------------------------
	localparam logic [3:0] ADDR_CHAN_STATUS = 4'h0;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'h1;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h2;
	localparam logic [3:0] ADDR_OUT_PORT = 4'h3;
	localparam logic [3:0] ADDR_OUT_CFG = 4'h4;
	localparam logic [3:0] ADDR_VECTOR = 4'h5;
	localparam logic [3:0] ADDR_PRELOAD_HI = 4'h6;
	localparam logic [3:0] ADDR_PRELOAD_LO = 4'h7;
	localparam logic [3:0] ADDR_TIMER_HI = 4'h8;
	localparam logic [3:0] ADDR_TIMER_LO = 4'h9;
	localparam logic [3:0] ADDR_CLK_SEL = 4'hA;
	localparam logic [3:0] ADDR_GP_IN = 4'hB;
	localparam logic [3:0] ADDR_COMMAND = 4'hC;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CMD_TIMER_START = 0;
	localparam int CMD_TIMER_STOP = 1;
	localparam int CMD_CHAN_A_ON = 2;
	localparam int CMD_CHAN_A_OFF = 3;
	localparam int CMD_CHAN_B_ON = 4;
	localparam int CMD_CHAN_B_OFF = 5;
	localparam int CMD_END_SERVICE = 6;
	localparam int SEL_TIMER_EXT = 0;
	localparam int SEL_RX_CLK_A = 1;
	localparam int SEL_TX_CLK_B = 2;
	localparam int SEL_RX_CLK_B = 3;
	localparam int CFG_TIMER_OUT = 0;
	localparam int IRQ_TIMER_BIT = 3;
	localparam int TIMER_OUT_PIN = 3;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] VECTOR_RESET = 8'h0F;
	localparam logic [7:0] CLEAR_RESET = 8'h00;
	localparam logic [15:0] PRELOAD_RESET = 16'hFFFF;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLOCK_PERIOD_NS = 40;
	localparam int TICK_PERIOD_NS = 1000;
	localparam int TICK_CYCLES = TICK_PERIOD_NS / CLOCK_PERIOD_NS;

endpackage

/* src/sync2.sv */
// Two flip-flop synchroniser for a vector of pin levels.
// Assumes each bit is a slow level; no bus coherency is promised.
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] sync_next;

	// First stage feeds only the second
	always_comb begin
		meta_next = async_in;
		sync_next = meta_reg;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			meta_reg <= INIT;
			sync_reg <= INIT;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign sync_out = sync_reg;
endmodule // sync2
`default_nettype wire

/* src/irq_chain.sv */
// Interrupt request and daisy-chain enable logic.
// Assumes pending and chain_in are already in the clock domain.
`timescale 1ns/1ns
`default_nettype none
module irq_chain #(
	parameter bit CHAIN_MODE = 1'b1
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic pending,
	input wire logic chain_in,
	input wire logic end_service,
	output logic irq_request_n,
	output logic chain_enable_out
);
	logic req_n_reg;
	logic req_n_next;
	logic svc_reg;
	logic svc_next;
	logic ceo_reg;
	logic ceo_next;
	logic chain_ok;

	// Request, in-service latch and enable out
	always_comb begin
		chain_ok = !CHAIN_MODE || chain_in;
		req_n_next = !(pending && chain_ok);
		svc_next = svc_reg;
		if (end_service) begin
			svc_next = 1'b0;
		end
		if (CHAIN_MODE && !req_n_reg) begin
			svc_next = 1'b1; // Set beats a same-cycle clear
		end
		ceo_next = !CHAIN_MODE || (chain_in && !svc_next && req_n_next);
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			req_n_reg <= 1'b1;
			svc_reg <= 1'b0;
			ceo_reg <= 1'b1;
		end else begin
			req_n_reg <= req_n_next;
			svc_reg <= svc_next;
			ceo_reg <= ceo_next;
		end
	end

	assign irq_request_n = req_n_reg;
	assign chain_enable_out = ceo_reg;
endmodule // irq_chain
`default_nettype wire

/* sim/uart_host_reset_irq_chain_sva.sv */
// Port-level checks on the host control block.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module uart_host_reset_irq_chain_sva (
	input wire logic clock,
	input wire logic reset,
	input wire uart_ctl_pkg::host_bus_t host_bus,
	input wire logic host_data_oe,
	input wire logic [6:0] gp_inputs,
	input wire logic chain_enable_in,
	input wire logic [7:0] gp_outputs,
	input wire logic tx_line_a,
	input wire logic tx_line_b,
	input wire logic irq_request_n,
	input wire logic chain_enable_out,
	input wire logic timer_ext_clock,
	input wire logic tx_ext_clock_b,
	input wire logic timer_running
);
	// ----------------------------------------
	// Reset values, not disabled by reset itself
	// ----------------------------------------
	gp_reset_high_a: assert property (@(posedge clock) reset |=> gp_outputs == 8'hFF)
		else $error("outputs not high after reset");
	tx_reset_mark_a: assert property (@(posedge clock) reset |=> tx_line_a && tx_line_b)
		else $error("transmit lines not marking after reset");
	timer_reset_halt_a: assert property (@(posedge clock) reset |=> !timer_running)
		else $error("timer running after reset");
	// ----------------------------------------
	// Bus gating, three edge sync lag
	// ----------------------------------------
	bus_released_a: assert property (@(posedge clock) disable iff (reset) host_bus.cs_n [*4] |-> !host_data_oe)
		else $error("bus driven while deselected");
	oe_needs_select_a: assert property (@(posedge clock) disable iff (reset)
		$rose(host_data_oe) |-> $past(!host_bus.cs_n && !host_bus.rd_n, 3))
		else $error("bus driven without select and read");
	// ----------------------------------------
	// Daisy chain
	// ----------------------------------------
	chain_follow_a: assert property (@(posedge clock) disable iff (reset) !chain_enable_in [*4] |-> !chain_enable_out)
		else $error("chain out high while chain in low");
	request_blocked_a: assert property (@(posedge clock) disable iff (reset) !chain_enable_in [*4] |-> irq_request_n)
		else $error("request while chain in low");
	request_enabled_a: assert property (@(posedge clock) disable iff (reset)
		$fell(irq_request_n) |-> $past(chain_enable_in, 3))
		else $error("request raised without chain enable");
	service_hold_a: assert property (@(posedge clock) disable iff (reset) !irq_request_n |-> !chain_enable_out)
		else $error("chain out high during request");
	service_after_a: assert property (@(posedge clock) disable iff (reset) $rose(irq_request_n) |-> !chain_enable_out)
		else $error("chain out released before end of service");
	// ----------------------------------------
	// Pin clocks only follow a high pin
	// ----------------------------------------
	timer_pin_clock_a: assert property (@(posedge clock) disable iff (reset) timer_ext_clock |-> $past(gp_inputs[2], 3))
		else $error("timer clock pulse without input 2 high");
	txb_pin_clock_a: assert property (@(posedge clock) disable iff (reset) tx_ext_clock_b |-> $past(gp_inputs[5], 3))
		else $error("transmit clock pulse without input 5 high");
endmodule // uart_host_reset_irq_chain_sva

bind uart_host_reset_irq_chain uart_host_reset_irq_chain_sva uart_host_reset_irq_chain_sva_i (
	.clock(clock), .reset(reset), .host_bus(host_bus), .host_data_oe(host_data_oe),
	.gp_inputs(gp_inputs), .chain_enable_in(chain_enable_in), .gp_outputs(gp_outputs),
	.tx_line_a(tx_line_a), .tx_line_b(tx_line_b), .irq_request_n(irq_request_n),
	.chain_enable_out(chain_enable_out), .timer_ext_clock(timer_ext_clock),
	.tx_ext_clock_b(tx_ext_clock_b), .timer_running(timer_running)
);
`default_nettype wire

/* sim/chain_neighbour.sv */
// Upstream interrupt source on the daisy chain.
// Assumes claim comes from the bench; it pulls the chain low while set.
`timescale 1ns/1ns
`default_nettype none
module chain_neighbour (
	input wire logic clock,
	input wire logic claim,
	output logic chain_enable_in
);
	// Registered, so the chain drops one edge late like real logic
	always_ff @(posedge clock) begin
		chain_enable_in <= !claim;
	end
endmodule // chain_neighbour
`default_nettype wire

/* sim/uart_host_reset_irq_chain_bench.sv */
// Self-checking bench for the host control block.
// Assumes the checker is bound and the neighbour model drives chain in.
`timescale 1ns/1ns
`default_nettype none
module uart_host_reset_irq_chain_bench;
	logic clock = 1'b0;
	logic reset = 1'b1;
	uart_ctl_pkg::host_bus_t bus = 15'h7FFF;
	logic [6:0] gp = 7'h00;
	logic irq_ack_n = 1'b1;
	logic claim = 1'b0;
	logic [7:0] events = 8'h00;
	logic [7:0] chan_status = 8'h00;
	logic chain_in;
	logic [7:0] data_out, gp_out, rd;
	logic oe, tx_a_line, tx_b_line, req_n, chain_out, t_clk, rxa_clk, txb_clk, rxb_clk, running;
	int failures = 0;
	int checked = 0;
	int i, n_t, n_b, n_r;

	always #20 clock = ~clock;

	uart_host_reset_irq_chain #(.CHAIN_MODE(1'b1), .TICK_CYCLES(3)) uart_host_reset_irq_chain_i (
		.clock(clock), .reset(reset), .host_bus(bus), .host_data_out(data_out), .host_data_oe(oe),
		.gp_inputs(gp), .irq_ack_n(irq_ack_n), .chain_enable_in(chain_in), .irq_events(events),
		.chan_status_in(chan_status), .tx_data_a(1'b0), .tx_data_b(1'b0), .gp_outputs(gp_out),
		.tx_line_a(tx_a_line), .tx_line_b(tx_b_line), .irq_request_n(req_n), .chain_enable_out(chain_out),
		.timer_ext_clock(t_clk), .rx_ext_clock_a(rxa_clk), .tx_ext_clock_b(txb_clk),
		.rx_ext_clock_b(rxb_clk), .timer_running(running));
	chain_neighbour chain_neighbour_i (.clock(clock), .claim(claim), .chain_enable_in(chain_in));

	// ----------------------------------------
	// Helpers; drive and sample 4 ns after each rising edge
	// ----------------------------------------
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#4;
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	// Strobes held 4 clocks so the 2 flop sync never misses them
	task automatic bus_write(input logic [3:0] a, input logic [7:0] d);
		bus.addr = a;
		bus.data = d;
		bus.cs_n = 1'b0;
		bus.wr_n = 1'b0;
		step(4);
		bus = 15'h7FFF;
		step(4);
	endtask
	task automatic bus_read(input logic [3:0] a, output logic [7:0] d);
		int n;
		bus.addr = a;
		bus.cs_n = 1'b0;
		bus.rd_n = 1'b0;
		for (n = 0; n < 10 && oe !== 1'b1; n++) step(1);
		if (n == 10) begin
			failures++;
			$display("mismatch at %0t: read never answered", $time);
			tally_and_finish();
		end
		d = data_out;
		bus = 15'h7FFF;
		step(4);
	endtask
	task automatic wait_req(input logic lvl);
		int n;
		for (n = 0; n < 12 && req_n !== lvl; n++) step(1);
		check({7'h00, req_n}, {7'h00, lvl}, "request level");
		// A used-up wait ends the run at once
		if (n == 12) tally_and_finish();
	endtask
	task automatic pulse(input logic [7:0] e);
		events = e;
		step(1);
		events = 8'h00;
	endtask
	task automatic count_clocks(input int cycles);
		n_t = 0;
		n_b = 0;
		n_r = 0;
		repeat (cycles) begin
			step(1);
			if (t_clk === 1'b1) n_t++;
			if (rxa_clk !== 1'b0 || rxb_clk !== 1'b0) n_r++;
			if (txb_clk === 1'b1) n_b++;
		end
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		step(2);
		reset = 1'b0;
		step(4);
		check(gp_out, 8'hFF, "outputs after reset");
		check({6'h00, tx_a_line, tx_b_line}, 8'h03, "tx lines after reset");
		check({running, oe, req_n, chain_out}, 4'h3, "flags after reset");
		// Status, mask, port, config clear; vector loads 0F
		for (i = 1; i <= 5; i++) begin
			bus_read(i[3:0], rd);
			check(rd, (i == 5) ? 8'h0F : 8'h00, "reset register");
		end
		// Deselected read and write have no effect
		bus.rd_n = 1'b0;
		step(6);
		check({7'h00, oe}, 8'h00, "oe while deselected");
		bus = 15'h7FFF;
		bus.addr = uart_ctl_pkg::ADDR_IRQ_MASK;
		bus.data = 8'hFF;
		bus.wr_n = 1'b0;
		step(4);
		bus = 15'h7FFF;
		step(4);
		bus_read(uart_ctl_pkg::ADDR_IRQ_MASK, rd);
		check(rd, 8'h00, "mask after deselected write");
		// Mid-run reset after dirtying state
		bus_write(uart_ctl_pkg::ADDR_OUT_PORT, 8'h5A);
		check(gp_out, 8'hA5, "outputs follow port");
		bus_write(uart_ctl_pkg::ADDR_VECTOR, 8'h33);
		bus_write(uart_ctl_pkg::ADDR_IRQ_MASK, 8'h81);
		bus_write(uart_ctl_pkg::ADDR_COMMAND, 8'h15);
		check({7'h00, running}, 8'h01, "timer started");
		reset = 1'b1;
		step(2);
		reset = 1'b0;
		step(20);
		check({7'h00, running}, 8'h00, "timer stays halted");
		check({gp_out[7:1], tx_a_line & tx_b_line}, 8'hFF, "pins after second reset");
		bus_read(uart_ctl_pkg::ADDR_OUT_PORT, rd);
		check(rd, 8'h00, "port after reset");
		bus_read(uart_ctl_pkg::ADDR_IRQ_MASK, rd);
		check(rd, 8'h00, "mask after reset");
		bus_read(uart_ctl_pkg::ADDR_VECTOR, rd);
		check(rd, 8'h0F, "vector after reset");
		// Pin clocks for inputs 2 and 5, then deselected
		bus_write(uart_ctl_pkg::ADDR_CLK_SEL, 8'h0F);
		gp = 7'h74;
		count_clocks(8);
		check({n_t[3:0], n_b[3:0]}, 8'h11, "one pulse per rising pin");
		// Chain mode owns inputs 4 and 6, so receiver clocks stay quiet
		check(n_r[7:0], 8'h00, "no receiver clock in chain mode");
		bus_write(uart_ctl_pkg::ADDR_CLK_SEL, 8'h00);
		gp = 7'h00;
		step(6);
		gp = 7'h24;
		count_clocks(8);
		check({n_t[3:0], n_b[3:0]}, 8'h00, "no pulse when plain input");
		// Acknowledge cycle returns the vector, then plain read again
		chan_status = 8'h3C;
		irq_ack_n = 1'b0;
		step(4);
		irq_ack_n = 1'b1;
		bus_read(uart_ctl_pkg::ADDR_CHAN_STATUS, rd);
		check(rd, 8'h0F, "vector on acknowledge");
		bus_read(uart_ctl_pkg::ADDR_CHAN_STATUS, rd);
		check(rd, 8'h3C, "status after acknowledge");
		// Request, clear, end of service
		bus_write(uart_ctl_pkg::ADDR_IRQ_MASK, 8'h01);
		pulse(8'h02);
		step(8);
		check({7'h00, req_n}, 8'h01, "masked event");
		pulse(8'h01);
		wait_req(1'b0);
		check({7'h00, chain_out}, 8'h00, "chain out during request");
		bus_write(uart_ctl_pkg::ADDR_IRQ_STATUS, 8'h03);
		wait_req(1'b1);
		check({7'h00, chain_out}, 8'h00, "chain out until service end");
		bus_write(uart_ctl_pkg::ADDR_COMMAND, 8'h40);
		check({7'h00, chain_out}, 8'h01, "chain out after service end");
		// Upstream holds the chain: no request until it lets go
		claim = 1'b1;
		step(5);
		check({7'h00, chain_out}, 8'h00, "chain out follows chain in");
		pulse(8'h01);
		step(8);
		check({7'h00, req_n}, 8'h01, "no request while blocked");
		claim = 1'b0;
		wait_req(1'b0);
		bus_write(uart_ctl_pkg::ADDR_IRQ_STATUS, 8'h01);
		bus_write(uart_ctl_pkg::ADDR_COMMAND, 8'h40);
		check({6'h00, req_n, chain_out}, 8'h03, "chain released");
		tally_and_finish();
	end

	// Hang guard well above the sequence length
	initial begin
		#400000;
		failures++;
		$display("mismatch at %0t: run limit reached", $time);
		tally_and_finish();
	end
endmodule // uart_host_reset_irq_chain_bench
`default_nettype wire
